// ===== common/rxmon_pkg.sv
`default_nettype none
package rxmon_pkg;
  // ==========================================================================
  // Clock and interval timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned SEC_NS         = 1000000000;
  localparam int unsigned ONE_SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Register word indices
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_MFS    = 6'h01;
  localparam logic [5:0] REG_STATUS = 6'h02;
  localparam logic [5:0] REG_MPLS   = 6'h03;
  localparam logic [5:0] REG_IND    = 6'h04;
  localparam logic [5:0] REG_TOTAL  = 6'h05;
  localparam logic [5:0] REG_BIN0   = 6'h08;
  localparam logic [5:0] REG_CNT0   = 6'h18;
  localparam logic [5:0] REG_KEY0   = 6'h20;

  // ==========================================================================
  // Control fields
  localparam int unsigned CTRL_HIST_BIT  = 0;
  localparam int unsigned CTRL_HRST_BIT  = 1;
  localparam int unsigned CTRL_RUN_BIT   = 2;
  localparam int unsigned CTRL_IPM_BIT   = 3;
  localparam int unsigned CTRL_SEL_LSB   = 4;
  localparam int unsigned CTRL_FSEN_BIT  = 8;
  localparam int unsigned CTRL_FSPD_LSB  = 9;

  // ==========================================================================
  // Sizes and reset values
  localparam int unsigned BIN_COUNT    = 9;
  localparam int unsigned SRCH_ENTRIES = 4;
  localparam int unsigned GRP_COUNT    = 6;
  localparam logic [13:0] MFS_RST      = 14'h2580;
  localparam logic [13:0] LEN_SAT      = 14'h3FFF;
  localparam logic [7:0]  MPLS_NONE    = 8'hFF;
  localparam logic [13:0] BIN_UP [8]   = '{14'h0040, 14'h007F, 14'h00FF, 14'h01FF,
                                           14'h03FF, 14'h05EE, 14'h05F2, 14'h05F6};

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {IND_OK, IND_ANOM, IND_DEFECT, IND_UNDET} ind_e;
  typedef enum logic [2:0] {SEL_OFF, SEL_SRC_MAC, SEL_DST_MAC, SEL_VLAN,
                            SEL_SRC_IP4, SEL_DST_IP4, SEL_SRC_IP6, SEL_DST_IP6} sel_e;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_e;
endpackage
`default_nettype wire

// ===== verilog/rx_monitor.sv
// Decided for this implementation: register access over Avalon-MM and the address map.
`default_nettype none
module rx_monitor
  import rxmon_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = ONE_SEC_CYCLES
)(
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [5:0]   avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic      [31:0]  avs_readdata_o,
  output logic              avs_waitrequest_o,
  input  wire logic         rx_byte_valid_i,
  input  wire logic         rx_eof_i,
  input  wire logic [3:0]   rx_mpls_depth_i,
  input  wire logic         rx_vlan_tagged_i,
  input  wire logic [11:0]  rx_vlan_id_i,
  input  wire logic [47:0]  rx_src_mac_i,
  input  wire logic [47:0]  rx_dst_mac_i,
  input  wire logic         rx_is_ip4_i,
  input  wire logic         rx_is_ip6_i,
  input  wire logic [127:0] rx_src_ip_i,
  input  wire logic [127:0] rx_dst_ip_i,
  input  wire logic [5:0]   grp_anom_i,
  input  wire logic [5:0]   grp_defect_i,
  input  wire logic [5:0]   grp_traffic_i,
  input  wire logic         ref_present_i,
  input  wire logic         lock_acquired_i,
  input  wire logic         lock_failed_i,
  input  wire logic         sfp_signal_i,
  input  wire logic         an_done_i,
  input  wire logic [1:0]   an_speed_i,
  output logic      [1:0]   global_ind_o,
  output logic      [11:0]  grp_ind_o,
  output logic      [1:0]   ref_ind_o,
  output logic      [1:0]   lock_ind_o,
  output logic              speed_ten_gig_ind_o,
  output logic              speed_1000_ind_o,
  output logic              speed_100_ind_o,
  output logic              speed_10_ind_o,
  output logic              rx_act_ind_o
);

  // ==========================================================================
  // Functions
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = d[b*8 +: 8];
    return r;
  endfunction

  function automatic ind_e sev_merge(input ind_e a, input ind_e b);
    if (a == IND_DEFECT || b == IND_DEFECT)
      return IND_DEFECT;
    else if (a == IND_ANOM || b == IND_ANOM)
      return IND_ANOM;
    else if (a == IND_OK || b == IND_OK)
      return IND_OK;
    else
      return IND_UNDET;
  endfunction

  function automatic logic is_ip_sel(input sel_e s);
    return (s == SEL_SRC_IP4) || (s == SEL_DST_IP4) || (s == SEL_SRC_IP6) || (s == SEL_DST_IP6);
  endfunction

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // Bus slave: one wait state on every access
  logic        wait_r;
  logic [31:0] readdata_r;
  logic [31:0] rdata_nxt;
  logic        acc_wr;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_w;
  logic        run_cmd;

  assign acc_wr = avs_write_i && !wait_r;
  assign ctrl_w = merge_be(ctrl_word, avs_writedata_i, avs_byteenable_i);
  assign run_cmd = acc_wr && (avs_address_i == REG_CTRL) && avs_byteenable_i[0] && avs_writedata_i[CTRL_RUN_BIT];

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r     <= 1'b1;
      readdata_r <= 32'h0;
    end
    else
    begin
      wait_r <= !((avs_read_i || avs_write_i) && wait_r);
      if (avs_read_i && wait_r)
        readdata_r <= rdata_nxt;
    end
  end
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o    = readdata_r;

  // ==========================================================================
  // Control register
  logic        hist_en_r;
  logic        hist_rst;
  logic        ip_mode_r;
  sel_e        sel_r;
  logic        fspd_en_r;
  speed_e      fspd_r;
  logic [13:0] max_frame_size_setting_r;
  logic        test_run_r;
  logic        start;
  logic [31:0] mfs_w;

  assign ctrl_word = {21'h0, fspd_r, fspd_en_r, 1'b0, sel_r, ip_mode_r, 2'h0, hist_en_r};
  assign mfs_w     = merge_be({18'h0, max_frame_size_setting_r}, avs_writedata_i, avs_byteenable_i);
  assign hist_rst  = acc_wr && (avs_address_i == REG_CTRL) && avs_byteenable_i[0]
                     && avs_writedata_i[CTRL_HRST_BIT] && hist_en_r;
  assign start     = run_cmd && !test_run_r;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_en_r  <= 1'b0;
      ip_mode_r  <= 1'b0;
      sel_r      <= SEL_OFF;
      fspd_en_r  <= 1'b0;
      fspd_r     <= SPD_1000;
      test_run_r <= 1'b0;
      max_frame_size_setting_r <= MFS_RST;
    end
    else
    begin
      if (run_cmd)
        test_run_r <= !test_run_r;
      if (acc_wr && avs_address_i == REG_CTRL)
      begin
        hist_en_r <= ctrl_w[CTRL_HIST_BIT];
        ip_mode_r <= ctrl_w[CTRL_IPM_BIT];
        fspd_en_r <= ctrl_w[CTRL_FSEN_BIT];
        fspd_r    <= speed_e'(ctrl_w[CTRL_FSPD_LSB +: 2]);
        // An IP key without IP mode is refused; the old key stays unless it is an IP key, which falls to SEL_OFF
        if (!is_ip_sel(sel_e'(ctrl_w[CTRL_SEL_LSB +: 3])) || ctrl_w[CTRL_IPM_BIT])
          sel_r <= sel_e'(ctrl_w[CTRL_SEL_LSB +: 3]);
        else if (!ctrl_w[CTRL_IPM_BIT] && is_ip_sel(sel_r))
          sel_r <= SEL_OFF;
      end
      if (acc_wr && avs_address_i == REG_MFS)
        max_frame_size_setting_r <= mfs_w[13:0];
    end
  end

  // ==========================================================================
  // Frame length and size bins
  logic [13:0] len_cnt_r;
  logic [13:0] frame_len;
  logic        eof;
  logic [31:0] bins_r [BIN_COUNT];
  logic [3:0]  bin_idx;
  logic        bin_ok;

  assign eof       = rx_byte_valid_i && rx_eof_i;
  assign frame_len = (len_cnt_r == LEN_SAT) ? LEN_SAT : len_cnt_r + 14'h1;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      len_cnt_r <= 14'h0;
    else if (eof)
      len_cnt_r <= 14'h0;
    else if (rx_byte_valid_i && len_cnt_r != LEN_SAT)
      len_cnt_r <= len_cnt_r + 14'h1;
  end

  // Frames past the last bin bound and above the size setting are oversize and land in no bin
  always_comb
  begin
    bin_idx = 4'h8;
    for (int i = 7; i >= 0; i--)
      if (frame_len <= BIN_UP[i])
        bin_idx = 4'(i);
    bin_ok = (bin_idx != 4'h8) || (frame_len <= max_frame_size_setting_r);
  end

  for (genvar g = 0; g < BIN_COUNT; g++)
  begin : g_bin
    // Label depth is deliberately not looked at here
    always_ff @(posedge clk_i or negedge rst_n)
    begin
      if (!rst_n)
        bins_r[g] <= 32'h0;
      else if (start)
        bins_r[g] <= 32'h0;
      else if (test_run_r && eof && bin_ok && bin_idx == 4'(g))
        bins_r[g] <= bins_r[g] + 32'h1;
    end
  end

  // ==========================================================================
  // Label stack depth
  logic [7:0] mpls_min_r;
  logic [7:0] mpls_max_r;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mpls_min_r <= MPLS_NONE;
      mpls_max_r <= 8'h0;
    end
    else if (start)
    begin
      mpls_min_r <= MPLS_NONE;
      mpls_max_r <= 8'h0;
    end
    else if (test_run_r && eof)
    begin
      if ({4'h0, rx_mpls_depth_i} < mpls_min_r)
        mpls_min_r <= {4'h0, rx_mpls_depth_i};
      if ({4'h0, rx_mpls_depth_i} > mpls_max_r)
        mpls_max_r <= {4'h0, rx_mpls_depth_i};
    end
  end

  // ==========================================================================
  // Address search
  logic [127:0] obs_key;
  logic         obs_ok;
  logic [127:0] key_r [SRCH_ENTRIES];
  logic [31:0]  cnt_r [SRCH_ENTRIES];
  logic [SRCH_ENTRIES-1:0] vld_r;
  logic [SRCH_ENTRIES-1:0] hit;
  logic [1:0]   hit_idx;
  logic [1:0]   victim;
  logic [31:0]  total_r;

  always_comb
  begin
    obs_key = 128'h0;
    obs_ok  = 1'b0;
    case (sel_r)
      SEL_SRC_MAC: begin obs_key = {80'h0, rx_src_mac_i}; obs_ok = 1'b1; end
      SEL_DST_MAC: begin obs_key = {80'h0, rx_dst_mac_i}; obs_ok = 1'b1; end
      SEL_VLAN:    begin obs_key = {116'h0, rx_vlan_id_i}; obs_ok = rx_vlan_tagged_i; end
      SEL_SRC_IP4: begin obs_key = {96'h0, rx_src_ip_i[31:0]}; obs_ok = rx_is_ip4_i; end
      SEL_DST_IP4: begin obs_key = {96'h0, rx_dst_ip_i[31:0]}; obs_ok = rx_is_ip4_i; end
      SEL_SRC_IP6: begin obs_key = rx_src_ip_i; obs_ok = rx_is_ip6_i; end
      SEL_DST_IP6: begin obs_key = rx_dst_ip_i; obs_ok = rx_is_ip6_i; end
      default:     begin obs_key = 128'h0; obs_ok = 1'b0; end
    endcase
    obs_ok = obs_ok && test_run_r && eof && !start;
  end

  for (genvar g = 0; g < SRCH_ENTRIES; g++)
  begin : g_hit
    assign hit[g] = vld_r[g] && (key_r[g] == obs_key);
  end

  // A miss takes a free slot, else evicts the rarest key and inherits its count,
  // which keeps frequent keys in place at the cost of exact counts for newcomers
  always_comb
  begin
    hit_idx = 2'h0;
    victim  = 2'h0;
    for (int i = SRCH_ENTRIES - 1; i >= 0; i--)
      if (hit[i])
        hit_idx = 2'(i);
    for (int i = 1; i < SRCH_ENTRIES; i++)
      if (vld_r[victim] && (!vld_r[i] || cnt_r[i] < cnt_r[victim]))
        victim = 2'(i);
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vld_r   <= '0;
      total_r <= 32'h0;
      for (int i = 0; i < SRCH_ENTRIES; i++)
      begin
        key_r[i] <= 128'h0;
        cnt_r[i] <= 32'h0;
      end
    end
    else if (start)
    begin
      vld_r   <= '0;
      total_r <= 32'h0;
      for (int i = 0; i < SRCH_ENTRIES; i++)
        cnt_r[i] <= 32'h0;
    end
    else if (obs_ok)
    begin
      total_r <= total_r + 32'h1;
      if (|hit)
        cnt_r[hit_idx] <= cnt_r[hit_idx] + 32'h1;
      else
      begin
        key_r[victim] <= obs_key;
        cnt_r[victim] <= cnt_r[victim] + 32'h1;
        vld_r[victim] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Group and global indicators, evaluated with or without a test
  ind_e live [GRP_COUNT];
  ind_e hist_r [GRP_COUNT];
  ind_e glob;

  for (genvar g = 0; g < GRP_COUNT; g++)
  begin : g_grp
    always_comb
    begin
      if (grp_defect_i[g])
        live[g] = IND_DEFECT;
      else if (grp_anom_i[g])
        live[g] = IND_ANOM;
      else if (grp_traffic_i[g])
        live[g] = IND_OK;
      else
        live[g] = IND_UNDET;
    end

    // A new event in the reset cycle survives the reset
    always_ff @(posedge clk_i or negedge rst_n)
    begin
      if (!rst_n)
        hist_r[g] <= IND_UNDET;
      else if (!hist_en_r)
        hist_r[g] <= IND_UNDET;
      else if (live[g] == IND_ANOM || live[g] == IND_DEFECT)
        hist_r[g] <= hist_rst ? live[g] : sev_merge(hist_r[g], live[g]);
      else if (hist_rst)
        hist_r[g] <= IND_UNDET;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
      if (!rst_n)
        grp_ind_o[g*2 +: 2] <= IND_UNDET;
      else if (hist_en_r)
        grp_ind_o[g*2 +: 2] <= sev_merge(live[g], hist_r[g]);
      else
        grp_ind_o[g*2 +: 2] <= live[g];
    end
  end

  always_comb
  begin
    glob = IND_UNDET;
    for (int i = 0; i < GRP_COUNT; i++)
      glob = sev_merge(glob, hist_en_r ? sev_merge(live[i], hist_r[i]) : live[i]);
  end

  // ==========================================================================
  // Reference, lock, speed and activity indicators
  logic [31:0] sec_cnt_r;
  logic        sec_tick;
  logic        rx_seen_r;
  speed_e      spd;
  logic        spd_known;

  assign sec_tick  = (sec_cnt_r == SEC_CYCLES - 1);
  assign spd       = fspd_en_r ? fspd_r : speed_e'(an_speed_i);
  assign spd_known = (fspd_en_r || an_done_i) && !sfp_signal_i;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sec_cnt_r <= 32'h0;
    else if (sec_tick)
      sec_cnt_r <= 32'h0;
    else
      sec_cnt_r <= sec_cnt_r + 32'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_seen_r    <= 1'b0;
      rx_act_ind_o <= 1'b0;
    end
    else if (sec_tick)
    begin
      rx_act_ind_o <= rx_seen_r || eof;
      rx_seen_r    <= 1'b0;
    end
    else if (eof)
      rx_seen_r <= 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_ind_o        <= IND_UNDET;
      ref_ind_o           <= IND_DEFECT;
      lock_ind_o          <= IND_UNDET;
      speed_ten_gig_ind_o <= 1'b0;
      speed_1000_ind_o    <= 1'b0;
      speed_100_ind_o     <= 1'b0;
      speed_10_ind_o      <= 1'b0;
    end
    else
    begin
      global_ind_o <= glob;
      ref_ind_o    <= ref_present_i ? IND_OK : IND_DEFECT;
      if (!ref_present_i)
        lock_ind_o <= IND_UNDET;
      else if (lock_failed_i)
        lock_ind_o <= IND_DEFECT;
      else if (lock_acquired_i)
        lock_ind_o <= IND_OK;
      else
        lock_ind_o <= IND_ANOM;
      speed_ten_gig_ind_o <= sfp_signal_i;
      speed_1000_ind_o    <= spd_known && spd == SPD_1000;
      speed_100_ind_o     <= spd_known && spd == SPD_100;
      speed_10_ind_o      <= spd_known && spd == SPD_10;
    end
  end

  // ==========================================================================
  // Register read decode; unmapped words read as zero
  always_comb
  begin
    rdata_nxt = 32'h0;
    if (avs_address_i == REG_CTRL)
      rdata_nxt = ctrl_word;
    else if (avs_address_i == REG_MFS)
      rdata_nxt = {18'h0, max_frame_size_setting_r};
    else if (avs_address_i == REG_STATUS)
      rdata_nxt = {24'h0, rx_act_ind_o, spd_known, spd, lock_ind_o, ref_present_i, test_run_r};
    else if (avs_address_i == REG_MPLS)
      rdata_nxt = {16'h0, mpls_max_r, mpls_min_r};
    else if (avs_address_i == REG_IND)
      rdata_nxt = {14'h0, global_ind_o, ref_ind_o, lock_ind_o, grp_ind_o};
    else if (avs_address_i == REG_TOTAL)
      rdata_nxt = total_r;
    else if (avs_address_i >= REG_BIN0 && avs_address_i < REG_BIN0 + 6'(BIN_COUNT))
      rdata_nxt = bins_r[4'(avs_address_i - REG_BIN0)];
    else if (avs_address_i >= REG_CNT0 && avs_address_i < REG_CNT0 + 6'(SRCH_ENTRIES))
      rdata_nxt = cnt_r[2'(avs_address_i - REG_CNT0)];
    else if (avs_address_i >= REG_KEY0 && avs_address_i < REG_KEY0 + 6'(4 * SRCH_ENTRIES))
      rdata_nxt = key_r[avs_address_i[3:2]][avs_address_i[1:0]*32 +: 32];
  end

  // ==========================================================================
  // Checks
  a_bin_small_inc: assert property (@(posedge clk_i) disable iff (!rst_n)
    test_run_r && !start && eof && frame_len <= BIN_UP[0] |=> bins_r[0] == $past(bins_r[0]) + 32'h1)
    else $error("smallest bin did not count");
  a_mpls_min_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    test_run_r && !start && eof && rx_mpls_depth_i == 4'h0 ##1 !start [*3] |-> mpls_min_r == 8'h0)
    else $error("label minimum not forced to zero");
  a_mpls_max_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    test_run_r && !start && eof |=> mpls_max_r >= {4'h0, $past(rx_mpls_depth_i)})
    else $error("label maximum below observed depth");
  a_ip_key_mode: assert property (@(posedge clk_i) disable iff (!rst_n)
    is_ip_sel(sel_r) |-> ip_mode_r)
    else $error("IP search key without IP mode");
  a_search_total: assert property (@(posedge clk_i) disable iff (!rst_n)
    obs_ok |=> total_r == $past(total_r) + 32'h1 && (|vld_r))
    else $error("search observation not recorded");
  a_hist_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
    hist_en_r && grp_defect_i[0] ##1 (hist_en_r && !hist_rst) |=> grp_ind_o[1:0] == IND_DEFECT)
    else $error("defect not latched in history mode");
  a_live_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
    !hist_en_r |=> grp_ind_o[3:2] == $past(live[1]))
    else $error("live indicator does not follow event");
  a_lock_disabled: assert property (@(posedge clk_i) disable iff (!rst_n)
    !ref_present_i |=> lock_ind_o == IND_UNDET && ref_ind_o == IND_DEFECT)
    else $error("lock indicator active without reference");
  a_speed_single: assert property (@(posedge clk_i) disable iff (!rst_n)
    spd_known && spd != 2'h3 |=> $onehot({speed_1000_ind_o, speed_100_ind_o, speed_10_ind_o}))
    else $error("speed indicators not exactly one");
  a_rx_activity: assert property (@(posedge clk_i) disable iff (!rst_n)
    sec_tick && rx_seen_r |=> rx_act_ind_o ##1 (sec_cnt_r != 32'h0 || rx_act_ind_o))
    else $error("activity indicator missed a frame");

endmodule
`default_nettype wire

// ===== verification/eth_partner.sv
`default_nettype none
module eth_partner
(
  input  wire logic clk_i,
  output logic      valid_o,
  output logic      eof_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Frame source
  initial
  begin
    valid_o = 1'b0;
    eof_o   = 1'b0;
  end
  // One byte a cycle, first address byte to last check byte
  task automatic send(input int len);
    for (int i = 1; i <= len; i++)
    begin
      valid_o <= 1'b1;
      eof_o   <= (i == len);
      @(posedge clk_i);
    end
    // Idle cycle between frames, so a next call never rewrites the strobe in the same step
    valid_o <= 1'b0;
    eof_o   <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top
  import rxmon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, rx_byte_valid_i, rx_eof_i, a;
  logic         rx_vlan_tagged_i, rx_is_ip4_i, rx_is_ip6_i, ref_present_i, lock_acquired_i, lock_failed_i;
  logic         sfp_signal_i, an_done_i, speed_ten_gig_ind_o, speed_1000_ind_o, speed_100_ind_o;
  logic         speed_10_ind_o, rx_act_ind_o;
  logic [1:0]   an_speed_i, global_ind_o, ref_ind_o, lock_ind_o;
  logic [3:0]   avs_byteenable_i, rx_mpls_depth_i;
  logic [5:0]   avs_address_i, grp_anom_i, grp_defect_i, grp_traffic_i;
  logic [11:0]  rx_vlan_id_i, grp_ind_o;
  logic [31:0]  avs_writedata_i, avs_readdata_o, q;
  logic [47:0]  rx_src_mac_i, rx_dst_mac_i;
  logic [127:0] rx_src_ip_i, rx_dst_ip_i;
  int           n_errors = 0;
  int           comparisons = 0;
  int           cyc = 0;
  int           lens [9] = '{64, 127, 255, 511, 1023, 1518, 1522, 1526, 1527};

  // Short second keeps the activity test brief
  rx_monitor #(.SEC_CYCLES(100)) dut (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rx_byte_valid_i, .rx_eof_i, .rx_mpls_depth_i,
    .rx_vlan_tagged_i, .rx_vlan_id_i, .rx_src_mac_i, .rx_dst_mac_i, .rx_is_ip4_i, .rx_is_ip6_i, .rx_src_ip_i,
    .rx_dst_ip_i, .grp_anom_i, .grp_defect_i, .grp_traffic_i, .ref_present_i, .lock_acquired_i, .lock_failed_i,
    .sfp_signal_i, .an_done_i, .an_speed_i, .global_ind_o, .grp_ind_o, .ref_ind_o, .lock_ind_o,
    .speed_ten_gig_ind_o, .speed_1000_ind_o, .speed_100_ind_o, .speed_10_ind_o, .rx_act_ind_o);
  eth_partner p (.clk_i(clk_i), .valid_o(rx_byte_valid_i), .eof_o(rx_eof_i));

  always #10 clk_i = ~clk_i;

  // ==========================================
  // Helpers
  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
    avs_address_i   <= ad;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  // Guards against a hung handshake
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end

  // ==========================================
  // Tests
  initial
  begin
    clk_i  = 1'b0;
    rstn_i = 1'b0;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, rx_mpls_depth_i, rx_vlan_id_i} = '0;
    {rx_src_mac_i, rx_src_ip_i, rx_dst_ip_i, rx_is_ip4_i, rx_is_ip6_i, rx_vlan_tagged_i} = '0;
    {ref_present_i, lock_acquired_i, lock_failed_i, sfp_signal_i, an_done_i, an_speed_i} = '0;
    {grp_anom_i, grp_defect_i, grp_traffic_i} = '0;
    avs_byteenable_i = 4'hF;
    rx_dst_mac_i     = 48'h00AB12345678;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    settle();
    chk("undet", 32'(grp_ind_o), 32'hFFF);
    bus(0, REG_CTRL, 0);
    chk("ctrl", q, 32'h400);
    bus(0, REG_MFS, 0);
    chk("mfs", q, 32'h2580);
    $display("Test registers done");
    bus(1, REG_CTRL, 32'h24);
    for (int i = 0; i < 9; i++)
    begin
      rx_mpls_depth_i  <= 4'(i % 4);
      rx_vlan_tagged_i <= i[0];
      rx_src_mac_i     <= 48'(i);
      p.send(lens[i]);
    end
    bus(0, REG_MPLS, 0);
    chk("mpls", q, 32'h300);
    for (int i = 0; i < 9; i++)
    begin
      bus(0, REG_BIN0 + 6'(i), 0);
      chk("bin", q, 32'h1);
    end
    bus(0, REG_CNT0, 0);
    chk("count", q, 32'd9);
    bus(0, REG_KEY0, 0);
    chk("key", q, 32'h12345678);
    bus(0, REG_TOTAL, 0);
    chk("total", q, 32'd9);
    // Just past the key words, while entry 0 holds a key
    bus(0, 6'h30, 0);
    chk("unmapped", q, 32'h0);
    // Stops the test and asks for an IP key outside IP mode
    bus(1, REG_CTRL, 32'h54);
    bus(0, REG_CTRL, 0);
    chk("ip sel", q, 32'h20);
    bus(1, REG_CTRL, 32'h58);
    bus(0, REG_CTRL, 0);
    chk("ip mode sel", q, 32'h58);
    p.send(64);
    bus(0, REG_BIN0, 0);
    chk("stopped", q, 32'h1);
    // New run on the VLAN key: only the tagged frame enters the search, both frames are binned
    bus(1, REG_CTRL, 32'h34);
    rx_vlan_tagged_i <= 1'b0;
    p.send(64);
    rx_vlan_tagged_i <= 1'b1;
    rx_vlan_id_i     <= 12'hABC;
    p.send(64);
    bus(0, REG_TOTAL, 0);
    chk("vlan total", q, 32'd1);
    bus(0, REG_KEY0, 0);
    chk("vlan key", q, 32'hABC);
    bus(0, REG_BIN0, 0);
    chk("vlan bin", q, 32'h2);
    bus(0, REG_MPLS, 0);
    chk("mpls restart", q, 32'h0);
    a = 1'b0;
    repeat (200)
    begin
      @(posedge clk_i);
      a = a | rx_act_ind_o;
    end
    chk("act", 32'(a), 32'h1);
    repeat (250) @(posedge clk_i);
    chk("idle", 32'(rx_act_ind_o), 32'h0);
    $display("Test statistics done");
    grp_traffic_i <= 6'h3F;
    ref_present_i <= 1'b1;
    an_done_i     <= 1'b1;
    an_speed_i    <= 2'd1;
    grp_anom_i    <= 6'h04;
    settle();
    chk("ref", 32'(ref_ind_o), 32'h0);
    chk("lock", 32'(lock_ind_o), 32'h1);
    chk("spd", 32'({speed_ten_gig_ind_o, speed_1000_ind_o, speed_100_ind_o, speed_10_ind_o}), 32'h2);
    chk("grp", {18'h0, global_ind_o, grp_ind_o}, 32'h1010);
    lock_failed_i <= 1'b1;
    sfp_signal_i  <= 1'b1;
    grp_anom_i    <= 6'h00;
    settle();
    chk("fail", 32'(lock_ind_o), 32'h2);
    chk("ten", 32'({speed_ten_gig_ind_o, speed_1000_ind_o, speed_100_ind_o, speed_10_ind_o}), 32'h8);
    chk("live", {18'h0, global_ind_o, grp_ind_o}, 32'h0);
    lock_failed_i   <= 1'b0;
    lock_acquired_i <= 1'b1;
    sfp_signal_i    <= 1'b0;
    bus(1, REG_CTRL, 32'h100);
    settle();
    chk("green", 32'(lock_ind_o), 32'h0);
    chk("forced", 32'({speed_ten_gig_ind_o, speed_1000_ind_o, speed_100_ind_o, speed_10_ind_o}), 32'h1);
    bus(1, REG_CTRL, 32'h1);
    grp_defect_i  <= 6'h01;
    ref_present_i <= 1'b0;
    settle();
    grp_defect_i <= 6'h00;
    settle();
    chk("noref", 32'(lock_ind_o), 32'h3);
    chk("red", 32'(ref_ind_o), 32'h2);
    chk("hist", {18'h0, global_ind_o, grp_ind_o}, 32'h2002);
    bus(1, REG_CTRL, 32'h3);
    settle();
    chk("clear", {18'h0, global_ind_o, grp_ind_o}, 32'h0);
    $display("Test indicators done");
    results();
  end
endmodule
`default_nettype wire
